// ---- hw/lgrc_top.sv ----
// Run-state control for pattern, state-machine, Boolean generators and trace.
// Assumes one clock and a supervising controller issuing one-cycle commands.
//
// Overview of operation
// - All blocks start in reset after load
// - Leave reset only through setup command
// - Reset command keeps stored configuration, enters reset
// - Reset state disconnects every external pin unless another block runs
// - Reset zero-fills pattern and state memories
// - Ready keeps reserved pins unconnected unless another block runs
// - Run or step connects pins, starts operation
// - Run is single-shot unless continuous selected
// - Single-shot ends on capture count or end
// - Boolean generator always runs continuously
// - Continuous pattern wraps to first word
// - Continuous state machine runs until stop
// - Stop halts block; pins disconnect once no block runs
// - Step advances pattern or machine once
// - Setup stores configuration, routing, no connect
// - Blocks may start together synchronously
// - Step is one cycle; pattern never wraps
// - Trace enabled by default, per-block disable
`include "lgrc_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module lgrc_top
  import lgrc_pkg::*;
#(
  parameter int PAT_DEPTH = `LGRC_PAT_DEPTH,
  parameter int PAT_WIDTH = `LGRC_PAT_WIDTH,
  parameter int FSM_DEPTH = `LGRC_FSM_DEPTH,
  parameter int FSM_WIDTH = `LGRC_FSM_WIDTH,
  parameter int PINS = `LGRC_PINS,
  parameter int NB = `LGRC_NUM_BLK
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Commands, one bit per block, one-cycle pulses
  input wire logic [NB-1:0] cmd_setup_i,
  input wire logic [NB-1:0] cmd_run_i,
  input wire logic [NB-1:0] cmd_step_i,
  input wire logic [NB-1:0] cmd_stop_i,
  input wire logic [NB-1:0] cmd_reset_i,
  // Per-block configuration
  input wire logic [NB-1:0] continuous_i,
  input wire logic [NB-1:0] trace_enable_n_i,
  input wire logic [PINS-1:0] route_i,
  input wire logic [$clog2(PAT_DEPTH):0] pattern_len_i,
  input wire logic [31:0] sample_count_i,
  // Memory load port, written while in ready by setup
  input wire logic pat_wr_i,
  input wire logic [$clog2(PAT_DEPTH)-1:0] pat_addr_i,
  input wire logic [PAT_WIDTH-1:0] pat_data_i,
  input wire logic fsm_wr_i,
  input wire logic [$clog2(FSM_DEPTH)-1:0] fsm_addr_i,
  input wire logic [FSM_WIDTH-1:0] fsm_data_i,
  // Status
  output logic [2*NB-1:0] status_o,
  output logic busy_clearing_o,
  // Switch and generator outputs
  output logic [PINS-1:0] pin_connect_o,
  output logic [PAT_WIDTH-1:0] pat_word_o,
  output logic [FSM_WIDTH-1:0] fsm_word_o,
  output logic [NB-1:0] advance_o,
  output logic [NB-1:0] trace_capture_o
);

  localparam int PA = $clog2(PAT_DEPTH);
  localparam int FA = $clog2(FSM_DEPTH);
  localparam int CA = (PA > FA) ? PA : FA;

  // ==========================================================================
  // Per-block state
  // ==========================================================================
  lgrc_state_type state [NB];
  logic [NB-1:0] cont;
  logic [NB-1:0] stepping;
  logic [NB-1:0] step_done;
  logic [NB-1:0] single_done;
  logic [NB-1:0] trace_on;
  logic [PINS-1:0] route;
  logic [PA:0] pat_len;
  logic [31:0] samp_goal;

  logic [PAT_WIDTH-1:0] pat_mem [PAT_DEPTH];
  logic [FSM_WIDTH-1:0] fsm_mem [FSM_DEPTH];
  logic [PA-1:0] pat_ptr;
  logic [FA-1:0] fsm_ptr;
  logic [31:0] samp_cnt;
  logic clearing;
  logic [CA:0] clr_ptr;

  function automatic logic is_run(input lgrc_state_type s);
    return s == LGRC_RUNNING;
  endfunction

  // ==========================================================================
  // Decoding
  // ==========================================================================
  wire logic pat_run = is_run(state[`LGRC_BLK_PAT]);
  wire logic fsm_run = is_run(state[`LGRC_BLK_FSM]);
  wire logic any_run = pat_run | fsm_run | is_run(state[`LGRC_BLK_BOOL]) | is_run(state[`LGRC_BLK_TRACE]);
  wire logic pat_adv = advance_o[`LGRC_BLK_PAT];
  wire logic fsm_adv = advance_o[`LGRC_BLK_FSM];
  wire logic pat_last = ({1'b0, pat_ptr} + 1'b1) >= pat_len;
  wire logic samp_full = samp_cnt + 32'h1 >= samp_goal;
  // Single-shot end shared by generators and trace
  wire logic shot_end = (pat_run & pat_adv & pat_last & ~cont[`LGRC_BLK_PAT])
                        | (is_run(state[`LGRC_BLK_TRACE]) & samp_full);

  genvar g;
  generate
    for (g = 0; g < NB; g++) begin : gen_adv
      // Running blocks advance each cycle; stepped ones once
      assign advance_o[g] = is_run(state[g]) & (~stepping[g] | ~step_done[g]);
      assign trace_capture_o[g] = advance_o[g] & trace_on[g];
      assign status_o[2*g +: 2] = (state[g] == LGRC_RESET) ? `LGRC_ST_RESET
                                 : (state[g] == LGRC_READY) ? `LGRC_ST_READY : `LGRC_ST_RUN;
      assign single_done[g] = (g != `LGRC_BLK_BOOL) & ~cont[g] & ~stepping[g] & shot_end;
    end
  endgenerate

  // Pins connect only while some block runs
  assign pin_connect_o = any_run ? route : '0;
  assign busy_clearing_o = clearing;

  // ==========================================================================
  // State machines, one per block
  // ==========================================================================
  generate
    for (g = 0; g < NB; g++) begin : gen_fsm
      always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
          state[g] <= LGRC_RESET;
          cont[g] <= 1'b0;
          stepping[g] <= 1'b0;
          step_done[g] <= 1'b0;
          trace_on[g] <= 1'b1;
        end else if (cmd_reset_i[g]) begin
          state[g] <= LGRC_RESET;
          stepping[g] <= 1'b0;
          step_done[g] <= 1'b0;
        end else begin
          case (state[g])
            LGRC_RESET: begin
              if (cmd_setup_i[g]) begin
                state[g] <= LGRC_READY;
                trace_on[g] <= ~trace_enable_n_i[g];
              end
            end
            LGRC_READY: begin
              trace_on[g] <= ~trace_enable_n_i[g];
              if (cmd_run_i[g] | cmd_step_i[g]) begin
                state[g] <= LGRC_RUNNING;
                cont[g] <= continuous_i[g] | (g == `LGRC_BLK_BOOL);
                stepping[g] <= cmd_step_i[g];
                step_done[g] <= 1'b0;
              end
            end
            LGRC_RUNNING: begin
              if (cmd_stop_i[g] | single_done[g]) begin
                state[g] <= LGRC_READY;
                stepping[g] <= 1'b0;
              end else if (stepping[g]) begin
                step_done[g] <= ~cmd_step_i[g];
              end
            end
            default: state[g] <= LGRC_RESET;
          endcase
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Configuration, counters and memories
  // ==========================================================================
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      route <= '0;
      pat_len <= '0;
      samp_goal <= '0;
    end else if (|cmd_setup_i) begin
      route <= route_i;
      pat_len <= pattern_len_i;
      samp_goal <= sample_count_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i | (|(cmd_run_i | cmd_step_i) & ~any_run)) begin
      pat_ptr <= '0;
      fsm_ptr <= '0;
      samp_cnt <= '0;
    end else begin
      if (pat_adv) begin
        if (pat_last) begin
          // Wrap only in continuous non-stepped run
          pat_ptr <= (cont[`LGRC_BLK_PAT] & ~stepping[`LGRC_BLK_PAT]) ? '0 : pat_ptr;
        end else begin
          pat_ptr <= pat_ptr + 1'b1;
        end
      end
      if (fsm_adv) begin
        fsm_ptr <= fsm_mem[fsm_ptr][FA-1:0];
      end
      if (advance_o[`LGRC_BLK_TRACE]) begin
        samp_cnt <= samp_cnt + 32'h1;
      end
    end
  end

  // Zero-fill sweep on entry to reset
  wire logic clr_req = reset_i | (|cmd_reset_i);
  always_ff @(posedge ref_clk_i) begin
    if (clr_req) begin
      clearing <= 1'b1;
      clr_ptr <= '0;
    end else if (clearing) begin
      clr_ptr <= clr_ptr + 1'b1;
      if (clr_ptr == (CA+1)'((PA > FA ? PAT_DEPTH : FSM_DEPTH) - 1)) begin
        clearing <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (clearing) begin
      if (clr_ptr < (CA+1)'(PAT_DEPTH)) begin
        pat_mem[clr_ptr[PA-1:0]] <= '0;
      end
    end else if (pat_wr_i & (state[`LGRC_BLK_PAT] == LGRC_READY)) begin
      pat_mem[pat_addr_i] <= pat_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (clearing) begin
      if (clr_ptr < (CA+1)'(FSM_DEPTH)) begin
        fsm_mem[clr_ptr[FA-1:0]] <= '0;
      end
    end else if (fsm_wr_i & (state[`LGRC_BLK_FSM] == LGRC_READY)) begin
      fsm_mem[fsm_addr_i] <= fsm_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pat_word_o <= '0;
      fsm_word_o <= '0;
    end else begin
      pat_word_o <= pat_run ? pat_mem[pat_ptr] : '0;
      fsm_word_o <= fsm_run ? fsm_mem[fsm_ptr] : '0;
    end
  end

endmodule // lgrc_top
`default_nettype wire

// ---- common/lgrc_defines.svh ----
// Constants for the logic generator run control block.
// Assumes inclusion by bare name from the common folder.
`ifndef LGRC_DEFINES_SVH
`define LGRC_DEFINES_SVH
// Block indices
`define LGRC_BLK_PAT 2'h0
`define LGRC_BLK_FSM 2'h1
`define LGRC_BLK_BOOL 2'h2
`define LGRC_BLK_TRACE 2'h3
`define LGRC_NUM_BLK 4
// Status field encodings
`define LGRC_ST_RESET 2'h0
`define LGRC_ST_READY 2'h1
`define LGRC_ST_RUN 2'h2
// Defaults
`define LGRC_PAT_DEPTH 65536
`define LGRC_PAT_WIDTH 20
`define LGRC_FSM_DEPTH 8192
`define LGRC_FSM_WIDTH 32
`define LGRC_PINS 20
`endif

// ---- common/lgrc_pkg.sv ----
// Types for the logic generator run control block.
// Assumes lgrc_defines.svh is compiled alongside.
`default_nettype none
package lgrc_pkg;
  typedef enum logic [1:0] {
    LGRC_RESET,
    LGRC_READY,
    LGRC_RUNNING
  } lgrc_state_type;
endpackage
`default_nettype wire

// ---- bench/lgrc_ext_model.sv ----
// External circuit model that sits on the IO pins.
// Assumes a pull-up on every pin and the pattern word as the only driver.
`timescale 1ns/100ps
`default_nettype none
module lgrc_ext_model (
  // Block side
  input wire logic [19:0] connect_i,
  input wire logic [19:0] word_i,
  // Levels seen by the circuit
  output logic [19:0] pins_o
);
  // ==========================
  // Pin levels
  // An unconnected pin floats to its pull-up
  assign pins_o = (word_i & connect_i) | ~connect_i;
endmodule // lgrc_ext_model
`default_nettype wire

// ---- bench/lgrc_chk.sv ----
// Checker of the run control ports.
// Assumes it is bound into lgrc_top.
`timescale 1ns/100ps
`default_nettype none
module lgrc_chk #(
  parameter int PINS = 20,
  parameter int NB = 4
) (
  // Watched ports
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [NB-1:0] cmd_setup_i,
  input wire logic [NB-1:0] cmd_run_i,
  input wire logic [NB-1:0] cmd_step_i,
  input wire logic [NB-1:0] cmd_stop_i,
  input wire logic [NB-1:0] cmd_reset_i,
  input wire logic [2*NB-1:0] status_o,
  input wire logic busy_clearing_o,
  input wire logic [PINS-1:0] pin_connect_o,
  input wire logic [NB-1:0] advance_o,
  input wire logic [NB-1:0] trace_capture_o
);
  // ==========================
  // Properties
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  wire any_run = status_o[1] | status_o[3] | status_o[5] | status_o[7];
  sequence pat_go;
    status_o[1:0] == 2'h1 && cmd_run_i[0] && !cmd_reset_i[0];
  endsequence
  sequence pat_step;
    status_o[1:0] == 2'h1 && cmd_step_i[0] && !cmd_reset_i[0];
  endsequence
  load_rst_a: assert property ($fell(reset_i) |-> status_o == '0 && pin_connect_o == '0)
    else $error("blocks not in reset after load");
  clear_run_a: assert property ($fell(reset_i) |-> busy_clearing_o [*8])
    else $error("zero fill too short");
  stay_rst_a: assert property (status_o[1:0] == 2'h0 && !cmd_setup_i[0] |=> status_o[1:0] == 2'h0)
    else $error("left reset without setup");
  setup_rdy_a: assert property (status_o[1:0] == 2'h0 && cmd_setup_i[0] && !cmd_reset_i[0]
    |=> status_o[1:0] == 2'h1)
    else $error("setup did not reach ready");
  rst_cmd_a: assert property (cmd_reset_i[1] |=> status_o[3:2] == 2'h0)
    else $error("reset command ignored");
  idle_pins_a: assert property (!any_run |-> pin_connect_o == '0)
    else $error("pins connected while idle");
  run_go_a: assert property (pat_go |=> status_o[1:0] == 2'h2 && advance_o[0])
    else $error("run did not start");
  step_one_a: assert property (pat_step |=> advance_o[0] ##1 (cmd_step_i[0] || cmd_reset_i[0] || !advance_o[0]))
    else $error("step advanced more than once");
  stop_drop_a: assert property (status_o[1:0] == 2'h2 && cmd_stop_i[0] && !cmd_reset_i[0]
    |=> status_o[1:0] == 2'h1)
    else $error("stop did not halt");
  bool_keep_a: assert property (status_o[5:4] == 2'h2 && !cmd_stop_i[2] && !cmd_reset_i[2]
    |=> status_o[5:4] == 2'h2)
    else $error("boolean block stopped on its own");
  trace_sub_a: assert property ((trace_capture_o & ~advance_o) == '0)
    else $error("capture without advance");
endmodule // lgrc_chk
bind lgrc_top lgrc_chk #(.PINS(PINS), .NB(NB)) u_chk (.ref_clk_i, .reset_i, .cmd_setup_i, .cmd_run_i,
  .cmd_step_i, .cmd_stop_i, .cmd_reset_i, .status_o, .busy_clearing_o, .pin_connect_o, .advance_o,
  .trace_capture_o);
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the run control block.
// Assumes the design built with 16-word memories.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic ref_clk_i, reset_i, pat_wr_i, fsm_wr_i, busy_clearing_o;
  logic [3:0] cmd_setup_i, cmd_run_i, cmd_step_i, cmd_stop_i, cmd_reset_i, continuous_i;
  logic [3:0] trace_enable_n_i, advance_o, trace_capture_o, pat_addr_i, fsm_addr_i;
  logic [19:0] route_i, pat_data_i, pin_connect_o, pat_word_o, pins;
  logic [4:0] pattern_len_i;
  logic [31:0] sample_count_i, fsm_data_i, fsm_word_o;
  logic [7:0] status_o;
  logic [19:0] w[4];
  logic [19:0] q[$];
  int n_fail, checked, st[4], k, n;
  // ==========================
  // Clock, design and far side
  initial begin
    ref_clk_i = 0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  lgrc_top #(.PAT_DEPTH(16), .FSM_DEPTH(16)) DUT (.*);
  lgrc_ext_model EXT (.connect_i(pin_connect_o), .word_i(pat_word_o), .pins_o(pins));
  // ==========================
  // Tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task tick(input int c);
    repeat (c) @(posedge ref_clk_i);
    #1;
  endtask
  // Command c: 0 setup, 1 run, 2 step, 3 stop, 4 reset; model updated per block
  task cmd(input int c, input logic [3:0] m);
    case (c)
      0: cmd_setup_i = m;
      1: cmd_run_i = m;
      2: cmd_step_i = m;
      3: cmd_stop_i = m;
      default: cmd_reset_i = m;
    endcase
    tick(1);
    {cmd_setup_i, cmd_run_i, cmd_step_i, cmd_stop_i, cmd_reset_i} = '0;
    for (int b = 0; b < 4; b++) if (m[b]) begin
      case (c)
        0: if (st[b] == 0) st[b] = 1;
        1, 2: if (st[b] == 1) st[b] = 2;
        3: if (st[b] == 2) st[b] = 1;
        default: st[b] = 0;
      endcase
      chk(status_o[2*b+:2], st[b]);
    end
  endtask
  // ==========================
  // Watchdog and main sequence
  initial begin
    tick(5000);
    n_fail++;
    give_verdict;
  end
  initial begin
    void'($urandom(32'h19B7));
    {cmd_setup_i, cmd_run_i, cmd_step_i, cmd_stop_i, cmd_reset_i, continuous_i, trace_enable_n_i} = '0;
    {pat_wr_i, fsm_wr_i, pat_addr_i, fsm_addr_i, pat_data_i, fsm_data_i, route_i} = '0;
    pattern_len_i = 5'h04;
    sample_count_i = 32'h0000FFFF;
    n_fail = 0;
    checked = 0;
    st = '{default: 0};
    reset_i = 1;
    tick(3);
    reset_i = 0;
    chk(pins, 20'hFFFFF);
    k = 0;
    while (busy_clearing_o !== 1'b0 && k < 100) begin
      tick(1);
      k++;
    end
    if (k == 100) begin
      n_fail++;
      give_verdict;
    end
    cmd(1, 4'h1);
    cmd(2, 4'h1);
    route_i = 20'($urandom) | 20'h00001;
    cmd(0, 4'h1);
    chk(pin_connect_o, 0);
    cmd(1, 4'h1);
    n = 0;
    for (int i = 0; i < 20; i++) begin
      if (status_o[1:0] == 2'h2) begin
        chk(pin_connect_o, route_i);
        chk(pat_word_o, 0);
      end
      n += advance_o[0];
      tick(1);
    end
    st[0] = 1;
    chk(n, 4);
    chk(status_o[1:0], 1);
    for (int i = 0; i < 4; i++) begin
      w[i] = 20'($urandom << 3) | 20'(i + 1);
      pat_wr_i = 1;
      pat_addr_i = 4'(i);
      pat_data_i = w[i];
      tick(1);
    end
    pat_wr_i = 0;
    continuous_i = 4'h1;
    cmd(1, 4'h1);
    repeat (14) begin
      q.push_back(pat_word_o);
      tick(1);
    end
    k = 0;
    while (k < 4 && q[k] !== w[0]) k++;
    for (int i = 0; i < 8; i++) chk(q[k+i], w[i%4]);
    chk(status_o[1:0], 2);
    cmd(3, 4'h1);
    chk(pins, 20'hFFFFF);
    continuous_i = 4'h0;
    for (int i = 0; i < 6; i++) begin
      cmd(2, 4'h1);
      if (i < 4) chk(advance_o[0], 1);
      tick(1);
      chk(advance_o[0], 0);
    end
    tick(2);
    chk(pat_word_o, w[3]);
    cmd(3, 4'h1);
    cmd(0, 4'h1);
    continuous_i = 4'h2;
    trace_enable_n_i = 4'h2;
    cmd(0, 4'hE);
    cmd(1, 4'h6);
    chk(trace_capture_o[1], 0);
    chk(trace_capture_o[2], advance_o[2]);
    tick(20);
    chk(status_o[5:4], 2);
    chk(status_o[3:2], 2);
    chk(fsm_word_o, 0);
    cmd(4, 4'hF);
    chk(pin_connect_o, 0);
    give_verdict;
  end
endmodule // tb_top
`default_nettype wire
